// *** core/spg_consts.svh ***
// Constants for the servo pulse command, gear and torque limit block.
`ifndef SPG_CONSTS_SVH
`define SPG_CONSTS_SVH
`define SPG_FORM_NEG_FR 16'h0010
`define SPG_FORM_NEG_PS 16'h0011
`define SPG_FORM_NEG_AB 16'h0012
`define SPG_FORM_POS_FR 16'h0000
`define SPG_FORM_POS_PS 16'h0001
`define SPG_FORM_POS_AB 16'h0002
`define SPG_GEAR_W 16
`define SPG_DEV_W 32
`define SPG_TRQ_W 16
`define SPG_STEP_W 40
`define SPG_DEV_RST 32'h00000000
`define SPG_FRAC_RST 16'h0000
`define SPG_SETTLE_CYC 3'h7
`define SPG_CODE_RST 16'h0000
`endif

// *** core/spg_pkg.sv ***
// Types for the servo pulse command, gear and torque limit block.
package spg_pkg;
	typedef enum logic [2:0] {
		SPG_FR = 3'b001,
		SPG_PS = 3'b010,
		SPG_AB = 3'b100
	} spg_form_e;
	typedef struct packed {
		logic gear_select_high;
		logic gear_select_low;
		logic torque_limit_select;
	} spg_contacts_s;
	typedef struct packed {
		logic forward_pulse_input;
		logic reverse_pulse_input;
	} spg_pulses_s;
endpackage

// *** core/spg_sync.sv ***
// Three-stage input synchroniser with a second/third stage agreement filter.
`timescale 1ns/100ps
`default_nettype none
module spg_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	// The first stage is read only by the second, to keep metastability contained.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				dout <= s3_q;
			end
		end
	end
endmodule
`default_nettype wire

// *** core/spg_servo_cmd.sv ***
// Command pulse decoder, electronic gear, deviation counter and torque limit select.
// Operation
// R01: Negative logic forms by codes 0010/0011/0012.
// R02: Positive logic forms by codes 0000/0001/0002.
// R03: Quadrature counts every edge, four per cycle.
// R04: In-position when deviation magnitude within range.
// R05: In-position may hold during slow motion.
// R06: Gear selects pick one of four numerators.
// R07: New numerator applies at once on change.
// R08: Controller should enable smoothing against steps.
// R09: Contact shorted to common reads as one.
// R10: Torque always clamped to the valid limit.
// R11: Limit select honoured only when enabled.
// R12: Select low uses first torque limit.
// R13: Select high uses smaller of both limits.
// R14: Scaled command adds, feedback subtracts, deviation.
// R15: All pulse and contact inputs synchronised first.
`timescale 1ns/100ps
`default_nettype none
`include "spg_consts.svh"
module spg_servo_cmd
	import spg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire spg_pulses_s pulses,
	input wire spg_contacts_s contacts,
	input wire logic [15:0] pulse_form_code,
	input wire logic [`SPG_GEAR_W-1:0] gear_numerator_base,
	input wire logic [`SPG_GEAR_W-1:0] gear_numerator_alt1,
	input wire logic [`SPG_GEAR_W-1:0] gear_numerator_alt2,
	input wire logic [`SPG_GEAR_W-1:0] gear_numerator_alt3,
	input wire logic [`SPG_GEAR_W-1:0] gear_denominator,
	input wire logic [`SPG_DEV_W-1:0] in_position_range,
	input wire logic torque_select_enable,
	input wire logic [`SPG_TRQ_W-1:0] torque_limit_1,
	input wire logic [`SPG_TRQ_W-1:0] torque_limit_2,
	input wire logic [`SPG_TRQ_W-1:0] torque_command,
	input wire logic feedback_step,
	input wire logic feedback_dir,
	output logic in_position_flag,
	output logic [`SPG_DEV_W-1:0] deviation_count,
	output logic [`SPG_TRQ_W-1:0] torque_limit_valid,
	output logic [`SPG_TRQ_W-1:0] torque_out,
	output logic form_code_error
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_a_q;
	logic rst_n;
	// Asynchronous assert, synchronous release through two stages.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_a_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n <= rst_a_q;
		end
	end

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	// Inputs arrive already resolved: 1 means contact shorted to common.
	logic [4:0] raw_in;
	logic [4:0] syn;
	assign raw_in = {pulses.forward_pulse_input, pulses.reverse_pulse_input, // R09
		contacts.gear_select_high, contacts.gear_select_low, contacts.torque_limit_select};
	// One synchroniser per pin, contacts and pulses alike.
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			spg_sync u_sync ( // R15
				.clk(ref_clk),
				.rst_n(rst_n),
				.din(raw_in[gi]),
				.dout(syn[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Form decode
	// ------------------------------------------------------------
	// Decodes the form code into form and polarity; used for validity too.
	function automatic logic [4:0] decode_form(input logic [15:0] code);
		logic [4:0] r;
		r = 5'h00;
		if (code == `SPG_FORM_NEG_FR) begin
			r = {2'b11, SPG_FR}; // R01
		end else if (code == `SPG_FORM_NEG_PS) begin
			r = {2'b11, SPG_PS}; // R01
		end else if (code == `SPG_FORM_NEG_AB) begin
			r = {2'b11, SPG_AB}; // R01
		end else if (code == `SPG_FORM_POS_FR) begin
			r = {2'b10, SPG_FR}; // R02
		end else if (code == `SPG_FORM_POS_PS) begin
			r = {2'b10, SPG_PS}; // R02
		end else if (code == `SPG_FORM_POS_AB) begin
			r = {2'b10, SPG_AB}; // R02
		end
		return r;
	endfunction

	// Bit four marks a known code, bit three selects negative logic.
	logic [4:0] form_dec;
	logic form_valid;
	logic form_neg;
	spg_form_e form;
	assign form_dec = decode_form(pulse_form_code);
	assign form_valid = form_dec[4];
	assign form_neg = form_dec[3];
	assign form = spg_form_e'(form_dec[2:0]);

	// Negative logic: active when conducting, i.e. the synchronised level is one.
	// Positive logic inverts the sense.
	logic fp;
	logic rp;
	assign fp = form_neg ? syn[4] : ~syn[4]; // R02
	assign rp = form_neg ? syn[3] : ~syn[3]; // R02

	logic fp_q;
	logic rp_q;
	// Last cycle's decoded levels, the reference for edge detection.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fp_q <= 1'b0;
			rp_q <= 1'b0;
		end else begin
			fp_q <= fp;
			rp_q <= rp;
		end
	end

	// ------------------------------------------------------------
	// Settling guard
	// ------------------------------------------------------------
	// Edges are ignored after reset and after any change of form code until the
	// synchronisers have drained, because the decoded levels may jump then.
	logic [15:0] code_q;
	logic [2:0] settle_q;
	logic armed;
	assign armed = (settle_q == `SPG_SETTLE_CYC) && (pulse_form_code == code_q);

	// Counts the quiet cycles since the last reset release or code change.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			code_q <= `SPG_CODE_RST;
			settle_q <= 3'h0;
		end else begin
			code_q <= pulse_form_code;
			if (pulse_form_code != code_q) begin
				settle_q <= 3'h0;
			end else if (!armed) begin
				settle_q <= settle_q + 3'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Pulse decoding into a signed count of -1, 0 or +1
	// ------------------------------------------------------------
	logic cmd_step;
	logic cmd_rev;
	logic f_rise;
	logic r_rise;
	logic f_edge;
	logic r_edge;
	// Rising edges serve the two-train and pulse-and-sign forms; any edge serves quadrature.
	assign f_rise = fp & ~fp_q;
	assign r_rise = rp & ~rp_q;
	assign f_edge = fp ^ fp_q;
	assign r_edge = rp ^ rp_q;
	// At most one count per cycle; its direction travels with it.
	always_comb begin
		cmd_step = 1'b0;
		cmd_rev = 1'b0;
		case (form)
			SPG_FR: begin
				// Simultaneous forward and reverse pulses cancel.
				cmd_step = f_rise ^ r_rise; // R01
				cmd_rev = r_rise;
			end
			SPG_PS: begin
				cmd_step = f_rise; // R01
				cmd_rev = rp;
			end
			SPG_AB: begin
				// Every edge of either phase counts; both at once is a skipped state.
				cmd_step = f_edge ^ r_edge; // R03
				cmd_rev = f_edge ? (fp == rp) : (fp != rp); // R03
			end
			default: begin
				cmd_step = 1'b0;
				cmd_rev = 1'b0;
			end
		endcase
		// Nothing counts under an unknown code or while the inputs settle.
		if (!form_valid || !armed) begin
			cmd_step = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Electronic gear select
	// ------------------------------------------------------------
	logic [`SPG_GEAR_W-1:0] numerator;
	// Combinational select so a contact change takes effect on the next count.
	always_comb begin
		case ({syn[2], syn[1]}) // R07
			2'b00: numerator = gear_numerator_base; // R06
			2'b01: numerator = gear_numerator_alt1; // R06
			2'b10: numerator = gear_numerator_alt2; // R06
			default: numerator = gear_numerator_alt3; // R06
		endcase
	end

	// ------------------------------------------------------------
	// Deviation counter with gear remainder
	// ------------------------------------------------------------
	// The remainder keeps fractional gear ratios exact over long moves.
	// Limitation: the numerator must not exceed the denominator times 65535.
	logic [`SPG_GEAR_W-1:0] frac_q;
	logic [`SPG_STEP_W-1:0] acc;
	logic [`SPG_STEP_W-1:0] den_w;
	logic [`SPG_STEP_W-1:0] quot;
	logic [`SPG_STEP_W-1:0] remd;
	logic [`SPG_DEV_W-1:0] dev_q;
	logic [`SPG_DEV_W-1:0] dev_d;
	logic [`SPG_DEV_W-1:0] delta;
	// A zero denominator is read as one rather than stalling the divide.
	assign den_w = (gear_denominator == '0) ? `SPG_STEP_W'(1) : `SPG_STEP_W'(gear_denominator);
	assign acc = `SPG_STEP_W'(frac_q) + (cmd_step ? `SPG_STEP_W'(numerator) : '0);
	assign quot = acc / den_w;
	assign remd = acc % den_w;
	assign delta = cmd_rev ? (~quot[`SPG_DEV_W-1:0] + 32'h00000001) : quot[`SPG_DEV_W-1:0];

	// Command and feedback counts may land in the same cycle; both apply.
	always_comb begin
		dev_d = dev_q + delta; // R14
		if (feedback_step) begin
			dev_d = feedback_dir ? dev_d + 32'h00000001 : dev_d - 32'h00000001; // R14
		end
	end
	// The remainder moves only on a command count; feedback never touches it.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			frac_q <= `SPG_FRAC_RST;
			dev_q <= `SPG_DEV_RST;
		end else begin
			if (cmd_step) begin
				frac_q <= remd[`SPG_GEAR_W-1:0]; // R14
			end
			dev_q <= dev_d; // R14
		end
	end

	// ------------------------------------------------------------
	// In-position and status outputs
	// ------------------------------------------------------------
	logic [`SPG_DEV_W-1:0] dev_mag;
	// Magnitude of the next count, so the flag and the count agree in time.
	assign dev_mag = dev_d[`SPG_DEV_W-1] ? (~dev_d + 32'h00000001) : dev_d;
	// Flag follows droop magnitude only, so it may stay set in slow motion.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_position_flag <= 1'b0;
			deviation_count <= `SPG_DEV_RST;
			form_code_error <= 1'b0;
		end else begin
			in_position_flag <= (dev_mag <= in_position_range); // R04 R05
			deviation_count <= dev_d;
			form_code_error <= ~form_valid;
		end
	end

	// ------------------------------------------------------------
	// Torque limit
	// ------------------------------------------------------------
	logic [`SPG_TRQ_W-1:0] lim_d;
	// Raising the select without its enable leaves the first limit in force.
	always_comb begin
		lim_d = torque_limit_1; // R10 R12
		if (torque_select_enable && syn[0]) begin // R11
			lim_d = (torque_limit_2 < torque_limit_1) ? torque_limit_2 : torque_limit_1; // R13
		end
	end

	// Registered so every output comes from a flip-flop, at the cost of one cycle.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			torque_limit_valid <= '0;
			torque_out <= '0;
		end else begin
			torque_limit_valid <= lim_d;
			torque_out <= (torque_command > lim_d) ? lim_d : torque_command; // R10
		end
	end
endmodule
`default_nettype wire

// *** testbench/spg_servo_cmd_checker.sv ***
// Assertion checker for the servo pulse command block.
`timescale 1ns/100ps
`default_nettype none
`include "spg_consts.svh"
module spg_servo_cmd_checker
	import spg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire spg_pulses_s pulses,
	input wire spg_contacts_s contacts,
	input wire logic [15:0] pulse_form_code,
	input wire logic [31:0] in_position_range,
	input wire logic torque_select_enable,
	input wire logic [15:0] torque_limit_1,
	input wire logic [15:0] torque_limit_2,
	input wire logic [15:0] torque_command,
	input wire logic feedback_step,
	input wire logic feedback_dir,
	input wire logic in_position_flag,
	input wire logic [31:0] deviation_count,
	input wire logic [15:0] torque_limit_valid,
	input wire logic [15:0] torque_out,
	input wire logic form_code_error
);
	// ----------------------------------------
	// Settling and helpers
	// ----------------------------------------
	// Outputs stay at zero while the reset copy drains, so checks wait until it has.
	logic [2:0] up_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) up_q <= 3'h0;
		else if (up_q != 3'h7) up_q <= up_q + 3'h1;
	end
	wire live = (up_q == 3'h7);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	function automatic logic [31:0] lo(input logic [31:0] a, input logic [31:0] b);
		return (a < b) ? a : b;
	endfunction
	// Limits and contacts must sit still long enough to clear the synchroniser.
	sequence lim_calm;
		(live && $stable(torque_limit_1) && $stable(torque_limit_2) && $stable(contacts)
			&& $stable(torque_select_enable))[*7];
	endsequence
	// A lone encoder count, far from any pin edge still in flight.
	sequence fb_alone;
		(live && $stable(pulses) && !feedback_step)[*8] ##1 ($stable(pulses) && feedback_step);
	endsequence
	AST_TRQ_GATED: assert property (lim_calm ##0 !torque_select_enable |->
		torque_limit_valid == torque_limit_1) else $error("limit select used while off");
	AST_TRQ_SEL_LO: assert property (lim_calm ##0 !contacts.torque_limit_select |->
		torque_limit_valid == torque_limit_1) else $error("select low not first limit");
	AST_TRQ_SEL_HI: assert property (lim_calm ##0 (torque_select_enable
		&& contacts.torque_limit_select) |-> torque_limit_valid == lo(torque_limit_1,
		torque_limit_2)) else $error("select high not smaller limit");
	AST_TRQ_OUT: assert property ((live && $stable(torque_command)
		&& $stable(torque_limit_valid))[*3] |-> torque_out == lo(torque_command,
		torque_limit_valid)) else $error("torque not clamped");
	AST_FORM_ERR: assert property ((live && $stable(pulse_form_code))[*3] |->
		form_code_error == !(pulse_form_code inside {`SPG_FORM_NEG_FR, `SPG_FORM_NEG_PS,
		`SPG_FORM_NEG_AB, `SPG_FORM_POS_FR, `SPG_FORM_POS_PS, `SPG_FORM_POS_AB}))
		else $error("form code error flag wrong");
	AST_NO_COUNT: assert property ((live && form_code_error && !feedback_step)[*4] |=>
		$stable(deviation_count)) else $error("count under bad form code");
	AST_INP: assert property ((live && $stable(in_position_range))[*2] |->
		in_position_flag == (lo(deviation_count, -deviation_count) <= in_position_range))
		else $error("in-position flag wrong");
	AST_FB: assert property (fb_alone |=> deviation_count == $past(deviation_count)
		+ ($past(feedback_dir) ? 32'h1 : 32'hFFFFFFFF)) else $error("feedback count wrong");
endmodule
bind spg_servo_cmd spg_servo_cmd_checker spg_servo_cmd_checker_inst (.*);
`default_nettype wire

// *** testbench/spg_pulse_ctl.sv ***
// Model of the positioning controller that drives command pulses and contacts.
`timescale 1ns/100ps
`default_nettype none
module spg_pulse_ctl
	import spg_pkg::*;
(
	input wire logic ref_clk,
	output var spg_pulses_s pulses,
	output var spg_contacts_s contacts
);
	// ----------------------------------------
	// Line drive
	// ----------------------------------------
	logic [1:0] ph_q = 2'h0; // Quadrature index, A leads B when it counts up.
	logic pos_q = 1'b0; // Positive logic idles high, so every level is inverted.
	initial pulses = '0;
	initial contacts = '0;
	// Levels hold six cycles, three times the shortest the decoder accepts.
	task automatic hold(input logic f, input logic r);
		pulses.forward_pulse_input = f ^ pos_q;
		pulses.reverse_pulse_input = r ^ pos_q;
		repeat (6) @(posedge ref_clk);
		#1;
	endtask
	task automatic idle(input logic pos);
		pos_q = pos;
		ph_q = 2'h0;
		hold(1'b0, 1'b0);
	endtask
	// Form 0 is two trains, 1 is pulse and sign, 2 is quadrature; dir 1 is forward.
	task automatic send(input logic [1:0] f, input logic dir, input int n);
		repeat (n) begin
			if (f == 2'h2) begin
				ph_q = dir ? ph_q + 2'h1 : ph_q - 2'h1;
				hold(ph_q[1] ^ ph_q[0], ph_q[1]);
			end else if (f == 2'h1) begin
				hold(1'b0, !dir);
				hold(1'b1, !dir);
				hold(1'b0, 1'b0);
			end else begin
				hold(dir, !dir);
				hold(1'b0, 1'b0);
			end
		end
	endtask
	// Gear contacts change only between sends, with the lines at rest, so no
	// count meets a half-switched numerator.
	task automatic touch(input logic [2:0] c);
		contacts = c;
	endtask
endmodule
`default_nettype wire

// *** testbench/spg_servo_cmd_tb_top.sv ***
// Self-checking bench for the servo pulse command block.
`timescale 1ns/100ps
`default_nettype none
`include "spg_consts.svh"
module spg_servo_cmd_tb_top
	import spg_pkg::*;
;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	spg_pulses_s pulses;
	spg_contacts_s contacts;
	logic [15:0] pulse_form_code = 16'h0003;
	logic [15:0] gear_numerator_base = 16'h0001;
	logic [15:0] gear_numerator_alt1 = 16'h0003;
	logic [15:0] gear_numerator_alt2 = 16'h0005;
	logic [15:0] gear_numerator_alt3 = 16'h0007;
	logic [15:0] gear_denominator = 16'h0001;
	logic [31:0] in_position_range = 32'h0;
	logic torque_select_enable = 1'b0;
	logic [15:0] torque_limit_1 = 16'h0064;
	logic [15:0] torque_limit_2 = 16'h0;
	logic [15:0] torque_command = 16'h0;
	logic feedback_step = 1'b0;
	logic feedback_dir = 1'b0;
	logic in_position_flag;
	logic [31:0] deviation_count;
	logic [15:0] torque_limit_valid;
	logic [15:0] torque_out;
	logic form_code_error;
	int err_count = 0;
	int n_checks = 0;
	logic [31:0] exp_dev = 32'h0;
	logic [15:0] ev;
	logic [15:0] codes [6] = '{`SPG_FORM_NEG_FR, `SPG_FORM_NEG_PS, `SPG_FORM_NEG_AB,
		`SPG_FORM_POS_FR, `SPG_FORM_POS_PS, `SPG_FORM_POS_AB};
	// Each row is enable, select, second limit, expected valid limit.
	logic [33:0] tq [4] = '{{2'b01, 16'h003C, 16'h0064}, {2'b11, 16'h003C, 16'h003C},
		{2'b10, 16'h003C, 16'h0064}, {2'b11, 16'h0096, 16'h0064}};
	spg_servo_cmd spg_servo_cmd_inst (.*);
	spg_pulse_ctl spg_pulse_ctl_inst (.*);
	// ----------------------------------------
	// Clock, tasks and watchdog
	// ----------------------------------------
	initial forever #4 ref_clk = ~ref_clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Pins need about five cycles to reach the counter; the send leaves six already.
	task automatic go(input logic [1:0] f, input logic dir, input int n, input logic [31:0] s);
		spg_pulse_ctl_inst.send(f, dir, n);
		exp_dev = dir ? exp_dev + 32'(n) * s : exp_dev - 32'(n) * s;
		cyc(4);
		chk("deviation", deviation_count, exp_dev);
	endtask
	initial begin
		#400000;
		err_count++;
		conclude();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		cyc(3);
		nrst = 1'b1;
		cyc(8);
		go(2'h0, 1'b1, 2, 32'h0);
		chk("form_err", form_code_error, 32'h1);
		// Every form and polarity, reverse first; the quadrature forms end one phase off idle.
		foreach (codes[i]) begin
			pulse_form_code = codes[i];
			cyc(2);
			spg_pulse_ctl_inst.idle(!codes[i][4]);
			chk("form_err", form_code_error, 32'h0);
			go(codes[i][1:0], 1'b0, 2, 32'h1);
			go(codes[i][1:0], 1'b1, 3, 32'h1);
		end
		for (int g = 1; g < 4; g++) begin
			spg_pulse_ctl_inst.touch({g[1:0], 1'b0});
			cyc(8);
			go(2'h2, 1'b1, 2, 32'(2 * g + 1));
		end
		// Seven over two: the remainder carries, so two counts give exactly seven.
		gear_denominator = 16'h0002;
		spg_pulse_ctl_inst.send(2'h2, 1'b1, 2);
		exp_dev = exp_dev + 32'h00000007;
		cyc(4);
		chk("deviation", deviation_count, exp_dev);
		in_position_range = exp_dev - 32'h1;
		cyc(3);
		chk("in_pos", in_position_flag, 32'h0);
		in_position_range = exp_dev;
		cyc(3);
		chk("in_pos", in_position_flag, 32'h1);
		for (int i = 0; i < 3; i++) begin
			feedback_dir = (i == 0);
			feedback_step = 1'b1;
			cyc(1);
			feedback_step = 1'b0;
			cyc(10);
			exp_dev = (i == 0) ? exp_dev + 32'h1 : exp_dev - 32'h1;
			chk("deviation", deviation_count, exp_dev);
		end
		for (int i = 0; i < 4; i++) begin
			{torque_select_enable, torque_limit_2, ev} = {tq[i][33], tq[i][31:0]};
			spg_pulse_ctl_inst.touch({2'h0, tq[i][32]});
			torque_command = 16'(i * 50);
			cyc(12);
			chk("limit", torque_limit_valid, ev);
			chk("torque", torque_out, (torque_command < ev) ? torque_command : ev);
		end
		conclude();
	end
endmodule
`default_nettype wire
